// >>> core/tpo_pkg.sv
// Shared constants of the timed pattern output unit.
package tpo_pkg;

  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [27:0] IDX_PORT_VALUE    = 28'h5ffffc2;
  localparam logic [27:0] IDX_PIN_FN_HIGH   = 28'h5ffffcc;
  localparam logic [27:0] IDX_PIN_FN_LOW    = 28'h5ffffce;
  localparam logic [27:0] IDX_MODE          = 28'h5fffff0;
  localparam logic [27:0] IDX_TRIG_SEL      = 28'h5fffff1;
  localparam logic [27:0] IDX_UPPER_EN      = 28'h5fffff2;
  localparam logic [27:0] IDX_LOWER_EN      = 28'h5fffff3;
  localparam logic [27:0] IDX_UPPER_STAGED  = 28'h5fffff4;
  localparam logic [27:0] IDX_LOWER_STAGED  = 28'h5fffff5;
  localparam logic [27:0] IDX_UPPER_ALT     = 28'h5fffff6;
  localparam logic [27:0] IDX_LOWER_ALT     = 28'h5fffff7;
  localparam logic [27:0] IDX_GAP           = 28'h5fffff8;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] RST_PORT_VALUE = 16'h0000;
  localparam logic [15:0] RST_PIN_FN     = 16'h0000;
  localparam logic [7:0]  RST_MODE       = 8'hf0;
  localparam logic [7:0]  RST_TRIG_SEL   = 8'hff;
  localparam logic [7:0]  RST_ENABLE     = 8'h00;
  localparam logic [7:0]  RST_STAGED     = 8'h00;
  localparam logic [7:0]  RST_GAP        = 8'h01;

  // ----------------------------------------------------------------------
  // Field codes and layout
  // ----------------------------------------------------------------------
  localparam logic [1:0]  PIN_FN_PATTERN = 2'b11;
  localparam logic [3:0]  RESERVED_NIB   = 4'hf;
  localparam logic [7:0]  RESERVED_BYTE  = 8'hff;
  localparam int          TRIG_FIELD_W   = 2;
  localparam int          MODE_NOVL_LSB  = 0;

  // Non-overlap sequencer states, one-hot.
  typedef enum logic [1:0] {
    TPO_ST_IDLE = 2'b01,
    TPO_ST_GAP  = 2'b10
  } tpo_state_e;

endpackage : tpo_pkg

// >>> core/tpo_bus_handshake.sv
// Avalon-MM waitrequest sequencing for the register slave.
`timescale 1ns/1ns
module tpo_bus_handshake (
  input  wire logic i_clock,        // System clock.
  input  wire logic i_reset,        // Synchronous reset, active high.
  input  wire logic i_read,         // Avalon read request.
  input  wire logic i_write,        // Avalon write request.
  output logic      o_waitrequest,  // Registered waitrequest.
  output logic      o_capture,      // Pulse: build read data this cycle.
  output logic      o_accept        // Pulse: request completes at this edge.
);

  logic wait_r;
  logic wait_nxt;

  // Every request waits exactly one cycle, so read data can be registered.
  always_comb begin
    wait_nxt = 1'b1;
    if ((i_read || i_write) && wait_r) begin
      wait_nxt = 1'b0;
    end
  end

  // Register stage.
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= wait_nxt;
    end
  end

  assign o_waitrequest = wait_r;
  assign o_capture     = (i_read || i_write) && wait_r;
  assign o_accept      = (i_read || i_write) && !wait_r;

endmodule : tpo_bus_handshake

// >>> core/tpo_group.sv
// One 4-bit output group: trigger-driven update with optional non-overlap gap.
`timescale 1ns/1ns
module tpo_group #(
  parameter int GAP_W = 8                 // Width of the gap count.
) (
  input  wire logic             i_clock,     // System clock.
  input  wire logic             i_reset,     // Synchronous reset, active high.
  input  wire logic             i_fire,      // Selected compare match.
  input  wire logic             i_nonoverlap,// Non-overlap mode for this group.
  input  wire logic [GAP_W-1:0] i_gap,       // Gap in clock cycles.
  input  wire logic [3:0]       i_staged,    // Staged next pattern.
  input  wire logic [3:0]       i_enable,    // Per-bit update enable.
  input  wire logic [3:0]       i_current,   // Present port value.
  output logic      [3:0]       o_mask,      // Bits to load this cycle.
  output logic      [3:0]       o_value      // Values for loaded bits.
);

  tpo_pkg::tpo_state_e state_r, state_nxt;
  logic [GAP_W-1:0]    cnt_r, cnt_nxt;
  logic [3:0]          rise_r, rise_nxt;

  // In non-overlap mode with a non-zero gap, falling bits go first; rising bits wait it out, so edges never overlap.
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    rise_nxt  = rise_r;
    o_mask    = 4'h0;
    o_value   = 4'h0;
    case (state_r)
      tpo_pkg::TPO_ST_GAP: begin
        cnt_nxt = cnt_r - 1'b1;
        if (cnt_r <= 1) begin
          o_mask    = rise_r;
          o_value   = 4'hf;
          state_nxt = tpo_pkg::TPO_ST_IDLE;
        end
      end
      default: state_nxt = tpo_pkg::TPO_ST_IDLE;
    endcase
    // A new trigger replaces any rising bits still waiting.
    if (i_fire) begin
      if (i_nonoverlap && (i_gap != '0)) begin
        o_mask    = i_enable & i_current & ~i_staged;
        o_value   = 4'h0;
        rise_nxt  = i_enable & ~i_current & i_staged;
        cnt_nxt   = i_gap;
        state_nxt = tpo_pkg::TPO_ST_GAP;
      end else begin
        o_mask    = i_enable;
        o_value   = i_staged;
        state_nxt = tpo_pkg::TPO_ST_IDLE;
      end
    end
  end

  // Register stage.
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_r <= tpo_pkg::TPO_ST_IDLE;
      cnt_r   <= '0;
      rise_r  <= 4'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      rise_r  <= rise_nxt;
    end
  end

endmodule : tpo_group

// >>> core/tpo_unit.sv
// Top of the timed pattern output unit: register slave, triggers and pins.
`timescale 1ns/1ns
module tpo_unit #(
  parameter int GAP_W = 8                          // Width of the gap count.
) (
  input  wire logic        i_clock,               // 10 MHz system clock.
  input  wire logic        i_reset,               // Synchronous reset, active high.
  input  wire logic [27:0] i_avs_address,         // Word index.
  input  wire logic        i_avs_read,            // Read request.
  input  wire logic        i_avs_write,           // Write request.
  input  wire logic [31:0] i_avs_writedata,       // Write data.
  input  wire logic [3:0]  i_avs_byteenable,      // Byte lanes.
  output logic      [31:0] o_avs_readdata,        // Read data.
  output logic             o_avs_waitrequest,     // Wait request.
  input  wire logic [3:0]  i_compare_match,       // Timer channel compare pulses.
  output logic      [3:0]  o_dma_request,         // Per-group DMA start pulse.
  output logic      [15:0] o_pattern_pins,        // Pattern pin levels.
  output logic      [15:0] o_pattern_oe           // Pattern pin drive enables.
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // Only bits 27..24 and 8..0 of the index take part in decode.
  function automatic logic hit(input logic [27:0] a, input logic [27:0] idx);
    hit = (a[27:24] == idx[27:24]) && (a[8:0] == idx[8:0]);
  endfunction : hit

  // Byte-lane merge for a 16-bit register.
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : merge16

  // ----------------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------------
  logic capture;
  logic accept;
  logic wr_acc;

  tpo_bus_handshake u_hs (
    .i_clock       (i_clock),
    .i_reset       (i_reset),
    .i_read        (i_avs_read),
    .i_write       (i_avs_write),
    .o_waitrequest (o_avs_waitrequest),
    .o_capture     (capture),
    .o_accept      (accept)
  );

  assign wr_acc = accept && i_avs_write;

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic [15:0]      port_r,   port_nxt;
  logic [15:0]      fnhi_r,   fnhi_nxt;
  logic [15:0]      fnlo_r,   fnlo_nxt;
  logic [7:0]       mode_r,   mode_nxt;
  logic [7:0]       trig_r,   trig_nxt;
  logic [7:0]       enhi_r,   enhi_nxt;
  logic [7:0]       enlo_r,   enlo_nxt;
  logic [7:0]       sthi_r,   sthi_nxt;
  logic [7:0]       stlo_r,   stlo_nxt;
  logic [GAP_W-1:0] gap_r,    gap_nxt;
  logic [31:0]      rdata_r,  rdata_nxt;
  logic [15:0]      pins_r,   pins_nxt;
  logic [15:0]      oe_r,     oe_nxt;
  logic [3:0]       dma_r,    dma_nxt;

  logic [15:0] enable_all;
  logic [7:0]  wb;
  logic        same_lo;
  logic        same_hi;
  logic [3:0]  fire;
  logic [15:0] hw_mask;
  logic [15:0] hw_val;
  logic [15:0] staged_all;
  logic [31:0] fn_all_nxt;

  // Flat views of paired registers, so each group and pin can take a slice.
  assign staged_all = {sthi_r, stlo_r};
  assign fn_all_nxt = {fnhi_nxt, fnlo_nxt};
  assign enable_all = {enhi_r, enlo_r};
  assign wb         = i_avs_byteenable[0] ? i_avs_writedata[7:0] : 8'h00;
  assign same_lo    = (trig_r[1:0] == trig_r[3:2]);
  assign same_hi    = (trig_r[5:4] == trig_r[7:6]);

  // ----------------------------------------------------------------------
  // Trigger selection and group sequencers
  // ----------------------------------------------------------------------
  // Each group samples the compare channel named by its two-bit field.
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_grp
      logic [1:0] sel;
      assign sel     = trig_r[g*tpo_pkg::TRIG_FIELD_W +: tpo_pkg::TRIG_FIELD_W];
      assign fire[g] = i_compare_match[sel];
      tpo_group #(.GAP_W(GAP_W)) u_grp (
        .i_clock      (i_clock),
        .i_reset      (i_reset),
        .i_fire       (fire[g]),
        .i_nonoverlap (mode_r[tpo_pkg::MODE_NOVL_LSB + g]),
        .i_gap        (gap_r),
        .i_staged     (staged_all[g*4 +: 4]),
        .i_enable     (enable_all[g*4 +: 4]),
        .i_current    (port_r[g*4 +: 4]),
        .o_mask       (hw_mask[g*4 +: 4]),
        .o_value      (hw_val[g*4 +: 4])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Register next values
  // ----------------------------------------------------------------------
  // Software writes land at the accept edge; hardware loads touch enabled
  // bits only, so the two never contend for the same port bit.
  always_comb begin
    port_nxt = port_r;
    fnhi_nxt = fnhi_r;
    fnlo_nxt = fnlo_r;
    mode_nxt = mode_r;
    trig_nxt = trig_r;
    enhi_nxt = enhi_r;
    enlo_nxt = enlo_r;
    sthi_nxt = sthi_r;
    stlo_nxt = stlo_r;
    gap_nxt  = gap_r;
    if (wr_acc) begin
      if (hit(i_avs_address, tpo_pkg::IDX_PORT_VALUE)) begin
        port_nxt = (merge16(port_r, i_avs_writedata, i_avs_byteenable) & ~enable_all)
                 | (port_r & enable_all);
      end
      if (hit(i_avs_address, tpo_pkg::IDX_PIN_FN_HIGH)) begin
        fnhi_nxt = merge16(fnhi_r, i_avs_writedata, i_avs_byteenable);
      end
      if (hit(i_avs_address, tpo_pkg::IDX_PIN_FN_LOW)) begin
        fnlo_nxt = merge16(fnlo_r, i_avs_writedata, i_avs_byteenable);
      end
      if (i_avs_byteenable[0]) begin
        if (hit(i_avs_address, tpo_pkg::IDX_MODE))     mode_nxt = wb;
        if (hit(i_avs_address, tpo_pkg::IDX_TRIG_SEL)) trig_nxt = wb;
        if (hit(i_avs_address, tpo_pkg::IDX_UPPER_EN)) enhi_nxt = wb;
        if (hit(i_avs_address, tpo_pkg::IDX_LOWER_EN)) enlo_nxt = wb;
        if (hit(i_avs_address, tpo_pkg::IDX_GAP))      gap_nxt  = wb[GAP_W-1:0];
        // Shared trigger: whole byte at the lower index; split: nibbles.
        if (hit(i_avs_address, tpo_pkg::IDX_LOWER_STAGED)) begin
          stlo_nxt = same_lo ? wb : {wb[7:4], stlo_r[3:0]};
        end
        if (hit(i_avs_address, tpo_pkg::IDX_LOWER_ALT) && !same_lo) begin
          stlo_nxt[3:0] = wb[3:0];
        end
        if (hit(i_avs_address, tpo_pkg::IDX_UPPER_STAGED)) begin
          sthi_nxt = same_hi ? wb : {wb[7:4], sthi_r[3:0]};
        end
        if (hit(i_avs_address, tpo_pkg::IDX_UPPER_ALT) && !same_hi) begin
          sthi_nxt[3:0] = wb[3:0];
        end
      end
    end
    // Triggered loads copy staged bits into enabled port bits only.
    port_nxt = (port_nxt & ~hw_mask) | (hw_val & hw_mask);
  end

  // Read data, output pins and DMA requests.
  always_comb begin
    rdata_nxt = rdata_r;
    if (capture) begin
      rdata_nxt = 32'h0000_0000;
      if (hit(i_avs_address, tpo_pkg::IDX_PORT_VALUE))  rdata_nxt[15:0] = port_r;
      if (hit(i_avs_address, tpo_pkg::IDX_PIN_FN_HIGH)) rdata_nxt[15:0] = fnhi_r;
      if (hit(i_avs_address, tpo_pkg::IDX_PIN_FN_LOW))  rdata_nxt[15:0] = fnlo_r;
      if (hit(i_avs_address, tpo_pkg::IDX_MODE))        rdata_nxt[7:0]  = mode_r;
      if (hit(i_avs_address, tpo_pkg::IDX_TRIG_SEL))    rdata_nxt[7:0]  = trig_r;
      if (hit(i_avs_address, tpo_pkg::IDX_UPPER_EN))    rdata_nxt[7:0]  = enhi_r;
      if (hit(i_avs_address, tpo_pkg::IDX_LOWER_EN))    rdata_nxt[7:0]  = enlo_r;
      if (hit(i_avs_address, tpo_pkg::IDX_GAP))         rdata_nxt[GAP_W-1:0] = gap_r;
      if (hit(i_avs_address, tpo_pkg::IDX_LOWER_STAGED)) begin
        rdata_nxt[7:0] = same_lo ? stlo_r : {stlo_r[7:4], tpo_pkg::RESERVED_NIB};
      end
      if (hit(i_avs_address, tpo_pkg::IDX_LOWER_ALT)) begin
        rdata_nxt[7:0] = same_lo ? tpo_pkg::RESERVED_BYTE
                                 : {tpo_pkg::RESERVED_NIB, stlo_r[3:0]};
      end
      if (hit(i_avs_address, tpo_pkg::IDX_UPPER_STAGED)) begin
        rdata_nxt[7:0] = same_hi ? sthi_r : {sthi_r[7:4], tpo_pkg::RESERVED_NIB};
      end
      if (hit(i_avs_address, tpo_pkg::IDX_UPPER_ALT)) begin
        rdata_nxt[7:0] = same_hi ? tpo_pkg::RESERVED_BYTE
                                 : {tpo_pkg::RESERVED_NIB, sthi_r[3:0]};
      end
    end
    // Pins take the new port value at the same edge the port bit changes.
    pins_nxt = port_nxt;
    for (int i = 0; i < 16; i++) begin
      oe_nxt[i] = (fn_all_nxt[2*i +: 2] == tpo_pkg::PIN_FN_PATTERN);
    end
    dma_nxt = fire;
  end

  // ----------------------------------------------------------------------
  // Register stage
  // ----------------------------------------------------------------------
  // No standby input exists here; staged data simply persists until reset.
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      port_r  <= tpo_pkg::RST_PORT_VALUE;
      fnhi_r  <= tpo_pkg::RST_PIN_FN;
      fnlo_r  <= tpo_pkg::RST_PIN_FN;
      mode_r  <= tpo_pkg::RST_MODE;
      trig_r  <= tpo_pkg::RST_TRIG_SEL;
      enhi_r  <= tpo_pkg::RST_ENABLE;
      enlo_r  <= tpo_pkg::RST_ENABLE;
      sthi_r  <= tpo_pkg::RST_STAGED;
      stlo_r  <= tpo_pkg::RST_STAGED;
      gap_r   <= tpo_pkg::RST_GAP[GAP_W-1:0];
      rdata_r <= 32'h0000_0000;
      pins_r  <= tpo_pkg::RST_PORT_VALUE;
      oe_r    <= 16'h0000;
      dma_r   <= 4'h0;
    end else begin
      port_r  <= port_nxt;
      fnhi_r  <= fnhi_nxt;
      fnlo_r  <= fnlo_nxt;
      mode_r  <= mode_nxt;
      trig_r  <= trig_nxt;
      enhi_r  <= enhi_nxt;
      enlo_r  <= enlo_nxt;
      sthi_r  <= sthi_nxt;
      stlo_r  <= stlo_nxt;
      gap_r   <= gap_nxt;
      rdata_r <= rdata_nxt;
      pins_r  <= pins_nxt;
      oe_r    <= oe_nxt;
      dma_r   <= dma_nxt;
    end
  end

  assign o_avs_readdata = rdata_r;
  assign o_pattern_pins = pins_r;
  assign o_pattern_oe   = oe_r;
  assign o_dma_request  = dma_r;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_reset_values;
    @(posedge i_clock) $past(i_reset) |->
      mode_r == 8'hf0 && trig_r == 8'hff && port_r == 16'h0000 &&
      {enhi_r, enlo_r, sthi_r, stlo_r} == 32'h0000_0000;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("reset values wrong");

  property p_staged_reset;
    @(posedge i_clock) disable iff (i_reset)
      $past(i_reset) |-> sthi_r == 8'h00 && stlo_r == 8'h00;
  endproperty
  a_staged_reset: assert property (p_staged_reset) else $error("staged not cleared");

  property p_locked_bits;
    @(posedge i_clock) disable iff (i_reset)
      (wr_acc && hit(i_avs_address, tpo_pkg::IDX_PORT_VALUE) && hw_mask == 16'h0) |=>
      ((port_r & $past(enable_all)) == ($past(port_r) & $past(enable_all)));
  endproperty
  a_locked_bits: assert property (p_locked_bits) else $error("locked port bit written");

  property p_transfer;
    @(posedge i_clock) disable iff (i_reset)
      (fire[0] && !mode_r[0]) |=>
      ((port_r[3:0] & $past(enlo_r[3:0])) == ($past(stlo_r[3:0]) & $past(enlo_r[3:0])));
  endproperty
  a_transfer: assert property (p_transfer) else $error("group 0 transfer wrong");

  property p_dma;
    @(posedge i_clock) disable iff (i_reset)
      i_compare_match[trig_r[3:2]] |=> o_dma_request[1];
  endproperty
  a_dma: assert property (p_dma) else $error("dma request missing");

  property p_select;
    @(posedge i_clock) disable iff (i_reset)
      (i_compare_match == 4'h0) |=> o_dma_request == 4'h0;
  endproperty
  a_select: assert property (p_select) else $error("group fired without trigger");

  property p_gap;
    @(posedge i_clock) disable iff (i_reset)
      (fire[0] && mode_r[0] && gap_r > 1) |=>
      ((port_r[3:0] & ~$past(port_r[3:0]) & $past(enlo_r[3:0] & stlo_r[3:0])) == 4'h0);
  endproperty
  a_gap: assert property (p_gap) else $error("rising edge not delayed");

  property p_pins;
    @(posedge i_clock) disable iff (i_reset)
      !$past(i_reset) |-> o_pattern_pins == port_r &&
      o_pattern_oe[15] == (fnhi_r[15:14] == 2'b11);
  endproperty
  a_pins: assert property (p_pins) else $error("pins do not track port");

  property p_reserved;
    @(posedge i_clock) disable iff (i_reset)
      (capture && i_avs_read && hit(i_avs_address, tpo_pkg::IDX_LOWER_ALT)) |=>
      o_avs_readdata[7:4] == 4'hf;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not one");

  property p_split_lo;
    @(posedge i_clock) disable iff (i_reset)
      (wr_acc && !same_lo && hit(i_avs_address, tpo_pkg::IDX_LOWER_STAGED)) |=>
      stlo_r[3:0] == $past(stlo_r[3:0]);
  endproperty
  a_split_lo: assert property (p_split_lo) else $error("split low nibble overwritten");

  property p_mirror;
    @(posedge i_clock) disable iff (i_reset)
      (wr_acc && i_avs_address[27:24] == 4'h5 && i_avs_address[8:0] == 9'h1f0 &&
       i_avs_byteenable[0]) |=> mode_r == $past(i_avs_writedata[7:0]);
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror decode failed");

  c_transfer: cover property (@(posedge i_clock) disable iff (i_reset)
    fire[0] && enlo_r[0]);
  c_gap: cover property (@(posedge i_clock) disable iff (i_reset)
    fire[0] && mode_r[0] && gap_r > 1);
  c_split_read: cover property (@(posedge i_clock) disable iff (i_reset)
    capture && i_avs_read && !same_hi && hit(i_avs_address, tpo_pkg::IDX_UPPER_ALT));

endmodule : tpo_unit

// >>> testbench/tpo_timer_model.sv
// Timer compare-match source and DMA request counter facing the pattern unit.
`timescale 1ns/1ns
module tpo_timer_model (
  input  wire logic       i_clock,         // System clock.
  input  wire logic [3:0] i_dma_request,   // Per-group DMA start pulses.
  output logic      [3:0] o_compare_match  // Channel compare pulses.
);
  int dma_count [4];  // DMA starts seen per group.

  initial o_compare_match = 4'h0;

  // Each request stands one cycle, so one sample per edge counts it exactly once.
  always @(posedge i_clock) begin
    for (int g = 0; g < 4; g++) begin
      if (i_dma_request[g] === 1'b1) dma_count[g] <= dma_count[g] + 1;
    end
  end

  // A compare match is a one-cycle pulse on one channel, launched after an edge.
  task automatic fire(input int ch);
    @(posedge i_clock);
    o_compare_match <= 4'h1 << ch;
    @(posedge i_clock);
    o_compare_match <= 4'h0;
  endtask : fire
endmodule : tpo_timer_model

// >>> testbench/tpo_unit_bench.sv
// Register and trigger regression of the timed pattern output unit.
`timescale 1ns/1ns
module tpo_unit_bench;
  logic        i_clock = 1'b0;
  logic        i_reset = 1'b1;
  logic [27:0] addr    = 28'h0;
  logic        rd      = 1'b0;
  logic        wr_en   = 1'b0;
  logic [31:0] wdata   = 32'h0;
  logic [3:0]  be      = 4'hf;
  logic [31:0] rdata;
  logic        wait_req;
  logic [3:0]  match;
  logic [3:0]  dma;
  logic [15:0] pins;
  logic [15:0] oe;
  int          n_fail = 0;
  int          total_checks = 0;
  logic [27:0] rst_idx [9] = '{tpo_pkg::IDX_MODE, tpo_pkg::IDX_TRIG_SEL, tpo_pkg::IDX_UPPER_EN,
    tpo_pkg::IDX_LOWER_EN, tpo_pkg::IDX_UPPER_STAGED, tpo_pkg::IDX_LOWER_STAGED,
    tpo_pkg::IDX_PORT_VALUE, tpo_pkg::IDX_PIN_FN_HIGH, tpo_pkg::IDX_PIN_FN_LOW};
  logic [31:0] rst_val [9] = '{32'hf0, 32'hff, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

  always #50 i_clock = ~i_clock;

  tpo_unit DUT (.i_clock(i_clock), .i_reset(i_reset), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr_en), .i_avs_writedata(wdata), .i_avs_byteenable(be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req), .i_compare_match(match),
    .o_dma_request(dma), .o_pattern_pins(pins), .o_pattern_oe(oe));

  tpo_timer_model timer (.i_clock(i_clock), .i_dma_request(dma), .o_compare_match(match));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic stop_test;
    if (n_fail == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Waitrequest and read data are taken at the rising edge, before that edge's updates land.
  task automatic bus(input logic w, input logic [27:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge i_clock);
    rd    <= !w;
    wr_en <= w;
    addr  <= a;
    wdata <= d;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (wait_req !== 1'b0 && n < 50);
    if (wait_req !== 1'b0) begin
      n_fail++;
      stop_test();
    end else begin
      q = rdata;
      rd    <= 1'b0;
      wr_en <= 1'b0;
    end
  endtask : bus

  task automatic wr(input logic [27:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rdc(input logic [27:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rdc

  // Pins are compared once the updating edge has landed.
  task automatic pin_chk(input logic [15:0] e);
    @(negedge i_clock);
    chk({16'h0, pins}, {16'h0, e});
  endtask : pin_chk

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge i_clock);
    i_reset <= 1'b0;
    // Reset values, the mirrored decode and an unmapped index.
    for (int i = 0; i < 9; i++) rdc(rst_idx[i], rst_val[i]);
    rdc(tpo_pkg::IDX_LOWER_ALT, 32'hff);
    rdc(tpo_pkg::IDX_UPPER_ALT, 32'hff);
    rdc(tpo_pkg::IDX_MODE ^ 28'h0fffe00, 32'hf0);
    rdc(tpo_pkg::IDX_GAP, 32'h01);
    rdc(28'h5ffff00, 32'h0);
    // Pin function fields of 11 turn drive on for exactly those pins.
    wr(tpo_pkg::IDX_PIN_FN_LOW, 32'hffff);
    // Only the upper lane of the high field register is written here.
    be <= 4'h2;
    wr(tpo_pkg::IDX_PIN_FN_HIGH, 32'hc0ff);
    be <= 4'hf;
    @(negedge i_clock);
    chk({16'h0, oe}, 32'h80ff);
    // Enabled port bits refuse software writes.
    wr(tpo_pkg::IDX_LOWER_EN, 32'h0f);
    wr(tpo_pkg::IDX_LOWER_STAGED, 32'ha5);
    wr(tpo_pkg::IDX_PORT_VALUE, 32'h00ff);
    rdc(tpo_pkg::IDX_PORT_VALUE, 32'h00f0);
    // Shared trigger: channel 3 moves only the enabled nibble.
    timer.fire(3);
    pin_chk(16'h00f5);
    repeat (2) @(posedge i_clock);
    chk(timer.dma_count[0], 32'h1);
    // Split triggers relocate the staged nibbles.
    wr(tpo_pkg::IDX_TRIG_SEL, 32'he4);
    rdc(tpo_pkg::IDX_LOWER_STAGED, 32'haf);
    rdc(tpo_pkg::IDX_LOWER_ALT, 32'hf5);
    wr(tpo_pkg::IDX_LOWER_ALT, 32'h03);
    rdc(tpo_pkg::IDX_LOWER_ALT, 32'hf3);
    wr(tpo_pkg::IDX_UPPER_STAGED, 32'h9f);
    wr(tpo_pkg::IDX_UPPER_ALT, 32'hf6);
    rdc(tpo_pkg::IDX_UPPER_STAGED, 32'h9f);
    rdc(tpo_pkg::IDX_UPPER_ALT, 32'hf6);
    wr(tpo_pkg::IDX_UPPER_EN, 32'hff);
    // Each channel now moves its own group only.
    timer.fire(1);
    pin_chk(16'h00f5);
    timer.fire(0);
    pin_chk(16'h00f3);
    timer.fire(2);
    pin_chk(16'h06f3);
    timer.fire(3);
    pin_chk(16'h96f3);
    repeat (2) @(posedge i_clock);
    chk(timer.dma_count[0], 32'h2);
    chk(timer.dma_count[3], 32'h2);
    wr(tpo_pkg::IDX_PORT_VALUE, 32'h0000);
    rdc(tpo_pkg::IDX_PORT_VALUE, 32'h9603);
    // Non-overlap on group 0: falling bits first, rising bits one gap later.
    wr(tpo_pkg::IDX_MODE, 32'hf1);
    wr(tpo_pkg::IDX_GAP, 32'h03);
    rdc(tpo_pkg::IDX_GAP, 32'h03);
    wr(tpo_pkg::IDX_LOWER_ALT, 32'hfc);
    timer.fire(0);
    repeat (3) pin_chk(16'h9600);
    pin_chk(16'h960c);
    stop_test();
  end
endmodule : tpo_unit_bench
